/* File: verilog/sync_serial_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_consts.svh"

// How it works
// R1 - Full-duplex shifting and shared-line half-duplex.
// R2 - Baud generator makes the master shift clock.
// R3 - Separate transmit, receive and error interrupts.
// R4 - Character length 2 to 16 bits exactly.
// R5 - Master drives clock; slave follows external clock.
// R6 - Selectable LSB-first or MSB-first shifting.
// R7 - Selectable shift clock idle level.
// R8 - Phase picks shifting edge; latch opposite.
// R9 - Flag missed transmit load and receive overrun.
// R10 - Detect phase error and baud-rate error.
// R11 - Loop-back feeds transmit data to receiver.
// R12 - Interrupts on buffer empty, full, errors.
// R13 - Three pins with swappable data pins.
// R14 - SPI-compatible clocking and data conventions.
// R15 - Errors stay set until software clears.
module sync_serial_channel
    import serial_pkg::*;
#(
    parameter int BAUD_W = 16
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        dat_a_in,
    output logic             dat_a_out,
    output logic             dat_a_oe,
    input  wire logic        dat_b_in,
    output logic             dat_b_out,
    output logic             dat_b_oe,
    output logic             irq_tx,
    output logic             irq_rx,
    output logic             irq_err,
    output logic             irq
);

    logic [`CTRL_W-1:0] ctrl_q;      // Control register.
    logic [BAUD_W-1:0]  baud_q;      // Baud reload value.
    logic [15:0]        txbuf_q;     // Transmit buffer.
    logic               tx_full_q;   // Transmit buffer holds a character.
    logic [15:0]        rxbuf_q;     // Receive buffer.
    logic               rx_full_q;   // Receive buffer holds unread data.
    logic [`ST_W-1:0]   sts_q;       // Sticky event bits.
    logic [`ST_W-1:0]   mask_q;      // Interrupt mask.
    logic [`ST_W-1:0]   sts_set;     // Events of this cycle.
    logic [31:0]        rdata_q;     // Read data captured in setup.
    logic               rd_valid_q;  // The captured address was mapped.
    shift_state_e       state_q;     // Shift engine state.
    logic [15:0]        tx_sh_q;     // Transmit shift register.
    logic [15:0]        rx_sh_q;     // Receive shift register.
    logic [4:0]         ecnt_q;      // Clock edges seen in this character.
    logic               sclk_q;      // Master clock level.
    logic               sclk_prev_q; // Last sampled slave clock level.
    logic               loaded_q;    // Slave shifter holds a fresh char.
    logic [3:0]         gap_q;       // Cycles since the last slave edge.
    logic               ph_chk_q;    // Re-check the bit just latched.
    logic               ph_bit_q;    // Bit that was latched.
    logic [4:0]         lat_cnt_q;   // Latched bits, for checking only.

    // Decoded control fields.
    logic       en, master, msb_first, cpol, cpha, loopback, half, swap;
    logic [3:0] lenm1;               // Character length minus one.
    logic [4:0] last_edge;           // Index of the final clock edge.
    assign en        = ctrl_q[`CTRL_ENABLE];
    assign master    = ctrl_q[`CTRL_MASTER];
    assign msb_first = ctrl_q[`CTRL_MSB_FIRST];
    assign cpol      = ctrl_q[`CTRL_CPOL];
    assign cpha      = ctrl_q[`CTRL_CPHA];
    assign loopback  = ctrl_q[`CTRL_LOOPBACK];
    assign half      = ctrl_q[`CTRL_HALF];
    assign swap      = ctrl_q[`CTRL_SWAP];

    // A length field of zero would mean one bit, so it counts as two.
    assign lenm1 = (ctrl_q[`CTRL_LEN_MSB:`CTRL_LEN_LSB] == 4'h0) ? 4'h1 :
                   ctrl_q[`CTRL_LEN_MSB:`CTRL_LEN_LSB]; // R4
    assign last_edge = {lenm1, 1'b1}; // R4

    // APB decode: accesses complete in their first access cycle.
    logic acc, wr, rd;
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign rd      = acc && !pwrite;
    assign pready  = acc;
    assign pslverr = acc && !rd_valid_q;
    assign prdata  = rdata_q;

    // Read data is captured in the setup cycle so it comes from a flop.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q    <= 32'h0000_0000;
            rd_valid_q <= 1'b0;
        end else if (psel && !penable) begin
            rd_valid_q <= 1'b1;
            case (paddr)
                `REG_CTRL:   rdata_q <= {20'h0_0000, ctrl_q};
                `REG_BAUD:   rdata_q <= {16'h0000, baud_q};
                `REG_TXDATA: rdata_q <= {16'h0000, txbuf_q};
                `REG_RXDATA: rdata_q <= {16'h0000, rxbuf_q};
                `REG_STATUS: rdata_q <= {25'h000_0000,
                                         state_q == SH_RUN, sts_q};
                `REG_MASK:   rdata_q <= {26'h000_0000, mask_q};
                default: begin
                    rdata_q    <= 32'h0000_0000;
                    rd_valid_q <= 1'b0;
                end
            endcase
        end
    end

    // Software writable configuration.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl_q <= `CTRL_RESET;
            baud_q <= `BAUD_RESET;
            mask_q <= `MASK_RESET;
        end else if (wr) begin
            if (paddr == `REG_CTRL) begin
                ctrl_q <= pwdata[`CTRL_W-1:0];
            end
            if (paddr == `REG_BAUD) begin
                baud_q <= pwdata[BAUD_W-1:0];
            end
            if (paddr == `REG_MASK) begin
                mask_q <= pwdata[`ST_W-1:0];
            end
        end
    end

    // Master shift clock enable from the baud divider.
    logic tick;
    baud_gen #(
        .WIDTH   (BAUD_W)
    ) baud_gen_i (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (master && state_q == SH_RUN),
        .reload  (baud_q),
        .tick    (tick)
    ); // R2

    // Edge detection for both modes.
    logic edge_seen, new_level, leading, latch, shift, done, start_m;
    logic start_s, proc, tx_bit, rx_bit, out_on_b, drive, pin_in;
    always_comb begin
        if (master) begin
            edge_seen = tick; // R5
            new_level = ~sclk_q;
        end else begin
            edge_seen = en && (sclk_in != sclk_prev_q); // R5
            new_level = sclk_in;
        end
    end
    assign proc    = edge_seen && (state_q == SH_RUN || (!master && en));
    assign leading = (new_level != cpol); // R7
    assign latch   = proc && (leading ^ cpha); // R8 R14
    assign shift   = proc && !(leading ^ cpha) &&
                     !(cpha && ecnt_q == 5'h00); // R8
    assign done    = proc && (ecnt_q == last_edge); // R4
    assign start_m = en && master && state_q == SH_IDLE && tx_full_q;
    assign start_s = en && !master && state_q == SH_IDLE && !loaded_q &&
                     tx_full_q;

    // The head of the shifter is the bit on the line.
    assign tx_bit = msb_first ? tx_sh_q[lenm1] : tx_sh_q[0]; // R6

    // Pin mapping: the data output sits on pin A for a master, on pin B
    // for a slave, and swapping exchanges the two.
    assign out_on_b = master ~^ swap; // R13
    assign pin_in   = (out_on_b ^ half) ? dat_a_in : dat_b_in; // R13
    assign rx_bit   = loopback ? tx_bit : pin_in; // R11 R1
    assign drive    = en && !loopback; // R11

    // In half duplex the shared line is open drain so both ends may send.
    logic dat_o, dat_oe;
    assign dat_o     = half ? 1'b0 : tx_bit; // R1
    assign dat_oe    = drive && (!half || !tx_bit); // R1
    assign dat_a_out = out_on_b ? 1'b0 : dat_o;
    assign dat_a_oe  = out_on_b ? 1'b0 : dat_oe;
    assign dat_b_out = out_on_b ? dat_o : 1'b0;
    assign dat_b_oe  = out_on_b ? dat_oe : 1'b0;
    assign sclk_out  = (state_q == SH_RUN) ? sclk_q : cpol; // R7
    assign sclk_oe   = drive && master; // R5

    // Engine state and the edge counter.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= SH_IDLE;
            ecnt_q  <= 5'h00;
        end else if (!en) begin
            state_q <= SH_IDLE;
            ecnt_q  <= 5'h00;
        end else if (done) begin
            state_q <= SH_IDLE;
            ecnt_q  <= 5'h00;
        end else if (proc) begin
            state_q <= SH_RUN;
            ecnt_q  <= ecnt_q + 5'h01;
        end else if (start_m) begin
            state_q <= SH_RUN;
        end
    end

    // Master clock toggles on every tick and rests at the idle level.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sclk_q <= 1'b0;
        end else if (!master || state_q == SH_IDLE) begin
            sclk_q <= cpol; // R7
        end else if (tick) begin
            sclk_q <= ~sclk_q;
        end
    end

    // Slave clock sample and edge spacing watch.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b0;
            gap_q       <= 4'hF;
        end else begin
            sclk_prev_q <= (en && !master) ? sclk_in : cpol;
            if (edge_seen) begin
                gap_q <= 4'h0;
            end else if (gap_q != 4'hF) begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end

    // Transmit shifter: loads from the buffer, then moves one place.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_sh_q  <= 16'h0000;
            loaded_q <= 1'b0;
        end else if (start_m || start_s) begin
            tx_sh_q  <= txbuf_q;
            loaded_q <= !master;
        end else begin
            if (shift) begin
                tx_sh_q <= msb_first ? {tx_sh_q[14:0], 1'b0} :
                                       {1'b0, tx_sh_q[15:1]}; // R6
            end
            if (done || !en) begin
                loaded_q <= 1'b0;
            end
        end
    end

    // Receive shifter gathers one bit per latching edge.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_sh_q <= 16'h0000;
        end else if (latch) begin
            rx_sh_q <= msb_first ? {rx_sh_q[14:0], rx_bit} :
                                   {rx_bit, rx_sh_q[15:1]}; // R6
        end
    end

    // The finished character, right-aligned for LSB-first.
    logic [15:0] rx_next, rx_word;
    logic [3:0]  align;
    always_comb begin
        rx_next = 16'h0000;
        if (latch) begin
            rx_next = msb_first ? {rx_sh_q[14:0], rx_bit} :
                                  {rx_bit, rx_sh_q[15:1]};
        end else begin
            rx_next = rx_sh_q;
        end
        align = 4'hF - lenm1;
        if (msb_first) begin
            rx_word = rx_next & ~(16'hFFFE << lenm1); // R4
        end else begin
            rx_word = rx_next >> align; // R4
        end
    end

    // Buffers: software loads and reads, the engine empties and fills.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            txbuf_q   <= 16'h0000;
            tx_full_q <= 1'b0;
            rxbuf_q   <= 16'h0000;
            rx_full_q <= 1'b0;
        end else begin
            if (wr && paddr == `REG_TXDATA) begin
                txbuf_q   <= pwdata[15:0];
                tx_full_q <= 1'b1;
            end else if (start_m || start_s) begin
                tx_full_q <= 1'b0;
            end
            if (done) begin
                rxbuf_q   <= rx_word;
                rx_full_q <= 1'b1;
            end else if (rd && paddr == `REG_RXDATA) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // Phase check: the data line must hold one cycle past the latch.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ph_chk_q <= 1'b0;
            ph_bit_q <= 1'b0;
        end else begin
            ph_chk_q <= latch && !master && !loopback;
            ph_bit_q <= rx_bit;
        end
    end

    // Events of this cycle.
    always_comb begin
        sts_set            = '0;
        sts_set[`ST_TXE]   = start_m || start_s; // R12
        sts_set[`ST_RXF]   = done; // R12
        sts_set[`ST_TXERR] = !master && proc && state_q == SH_IDLE &&
                             !loaded_q; // R9
        sts_set[`ST_RXERR] = done && rx_full_q; // R9
        sts_set[`ST_PHERR] = ph_chk_q && (rx_bit != ph_bit_q); // R10
        sts_set[`ST_BRERR] = !master && proc && state_q == SH_RUN &&
                             gap_q < `MIN_EDGE_GAP; // R10
    end

    // Sticky status: a read clears only what it returned; set wins.
    logic [`ST_W-1:0] sts_clr;
    assign sts_clr = (rd && paddr == `REG_STATUS) ? rdata_q[`ST_W-1:0]
                                                   : '0;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set; // R15
        end
    end

    // Three request lines and their combined level.
    logic [`ST_W-1:0] pend;
    assign pend    = sts_q & mask_q;
    assign irq_tx  = pend[`ST_TXE]; // R3
    assign irq_rx  = pend[`ST_RXF]; // R3
    assign irq_err = |pend[`ST_BRERR:`ST_TXERR]; // R3
    assign irq     = |pend;

    // Counts latched bits per character for the length check.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lat_cnt_q <= 5'h00;
        end else if (done || !en) begin
            lat_cnt_q <= 5'h00;
        end else if (latch) begin
            lat_cnt_q <= lat_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_LEN: assert property (done |->
        (lat_cnt_q + {4'h0, latch}) == ({1'b0, lenm1} + 5'h01)) // R4
        else $error("Character length does not match setting.");
    AST_IDLE_CLK: assert property (
        (en && master && state_q == SH_IDLE) |-> sclk_out == cpol) // R7
        else $error("Master clock not at its idle level.");
    AST_SLAVE_CLK: assert property (
        (en && !master) |-> !sclk_oe) // R5
        else $error("Slave drives the shift clock.");
    AST_BAUD: assert property (
        (tick && baud_q != '0) |=> !tick) // R2
        else $error("Baud ticks too close together.");
    AST_TXE: assert property (start_m |=> sts_q[`ST_TXE] && !tx_full_q
        || $past(wr)) // R12
        else $error("Transmit empty not flagged at load.");
    AST_RXF: assert property (done |=>
        state_q == SH_IDLE && sts_q[`ST_RXF] && rx_full_q) // R12
        else $error("Receive full not flagged at end.");
    AST_RXERR: assert property ((done && rx_full_q) |=>
        sts_q[`ST_RXERR]) // R9
        else $error("Overrun not flagged.");
    AST_STICKY: assert property ((sts_q[`ST_PHERR] &&
        !(rd && paddr == `REG_STATUS)) |=> sts_q[`ST_PHERR]) // R15
        else $error("Phase error dropped without a read.");
    AST_IRQ: assert property ((sts_q[`ST_BRERR] && mask_q[`ST_BRERR])
        |-> irq_err && irq) // R3
        else $error("Unmasked error raises no request.");
    AST_LOOP: assert property (loopback |->
        !dat_a_oe && !dat_b_oe && !sclk_oe) // R11
        else $error("Loop-back still drives the pins.");

    COV_MASTER: cover property (master && done);
    COV_SLAVE: cover property (!master && done);
    COV_PHASE: cover property (sts_set[`ST_PHERR]);

endmodule : sync_serial_channel

`default_nettype wire

/* File: verilog/serial_consts.svh */
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// Register byte offsets on the APB.
`define REG_CTRL        8'h00
`define REG_BAUD        8'h04
`define REG_TXDATA      8'h08
`define REG_RXDATA      8'h0C
`define REG_STATUS      8'h10
`define REG_MASK        8'h14

// Control register field positions.
`define CTRL_LEN_LSB    0
`define CTRL_LEN_MSB    3
`define CTRL_MSB_FIRST  4
`define CTRL_CPOL       5
`define CTRL_CPHA       6
`define CTRL_MASTER     7
`define CTRL_ENABLE     8
`define CTRL_LOOPBACK   9
`define CTRL_HALF       10
`define CTRL_SWAP       11
`define CTRL_W          12

// Status and mask bit positions.
`define ST_TXE          0
`define ST_RXF          1
`define ST_TXERR        2
`define ST_RXERR        3
`define ST_PHERR        4
`define ST_BRERR        5
`define ST_BUSY         6
`define ST_W            6

// Reset values.
`define CTRL_RESET      12'h007
`define BAUD_RESET      16'h0000
`define MASK_RESET      6'h00

// Least number of system clocks between two slave clock edges, not counting the edge cycles.
`define MIN_EDGE_GAP    4'h2

`endif

/* File: verilog/serial_pkg.sv */
`default_nettype none

package serial_pkg;

    // Shift engine states.
    typedef enum logic {
        SH_IDLE,
        SH_RUN
    } shift_state_e;

endpackage : serial_pkg

`default_nettype wire

/* File: verilog/baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// Divider that gives a one-cycle enable every reload+1 cycles while run.
module baud_gen #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] reload,
    output logic                  tick
);

    logic [WIDTH-1:0] cnt_q;   // Cycles left until the next tick.

    // The count restarts from the reload value whenever run is low.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (!run || cnt_q == '0) begin
            cnt_q <= reload;
        end else begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    // The tick fires as the count reaches zero.
    assign tick = run && (cnt_q == '0);

endmodule : baud_gen

`default_nettype wire

/* File: tb/spi_peer.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural SPI slave that answers the channel in master mode.
module spi_peer (
    input  wire logic        sclk,  // Shift clock from the master.
    input  wire logic        mosi,  // Data from the master.
    input  wire logic        arm,   // A rising edge starts a new frame.
    input  wire logic        cpol,  // Rest level of the clock.
    input  wire logic        cpha,  // Clock phase setting.
    input  wire logic        msb,   // Most significant bit goes first.
    input  wire logic [4:0]  len,   // Character length in bits.
    input  wire logic [15:0] tx,    // Character sent back.
    output logic             miso,  // Data to the master.
    output logic [15:0]      rx     // Character received, right-aligned.
);
    int k;  // Index of the bit now on the line.
    int n;  // Clock edges seen in this frame.

    // A new frame restarts the count; then latch on one edge and shift on
    // the other, as the phase says.
    always @(sclk or posedge arm) begin
        if (arm) begin
            {k, n, rx} = '0;
        end else begin
            if ((sclk !== cpol) ^ cpha) begin
                if (msb) begin
                    rx = {rx[14:0], mosi};
                end else begin
                    rx[k] = mosi;
                end
            end else if (n > 0 || !cpha) begin
                k = k + 1;
            end
            n = n + 1;
        end
    end

    // After the last bit the line no longer holds the old value.
    always @* begin
        if (k < len) begin
            miso = tx[msb ? len - 1 - k : k];
        end else begin
            miso = ~tx[msb ? 0 : len - 1];
        end
    end
endmodule : spi_peer

`default_nettype wire

/* File: tb/tb_sync_serial_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_consts.svh"

// Self-checking bench: APB master, link monitor and SPI peer.
module tb_sync_serial_channel
    import serial_pkg::*;
;
    logic        clock, reset_n;               // Clock and reset.
    logic        psel, penable, pwrite;        // APB request.
    logic [7:0]  paddr;                        // APB address.
    logic [31:0] pwdata, prdata, rv;           // APB data and last read.
    logic        pready, pslverr, ev;          // APB answer.
    logic        sclk_out, sclk_oe;            // Master shift clock.
    logic        dat_a_out, dat_a_oe;          // Data pin A.
    logic        dat_b_out, dat_b_oe;          // Data pin B.
    logic        irq_tx, irq_rx, irq_err, irq; // Interrupt lines.
    logic        drv_sclk, drv_a, swp, arm;    // Bench link drivers.
    logic        miso, p_cpol, p_cpha, p_msb;  // Peer settings.
    logic [4:0]  p_len;                        // Peer length.
    logic [15:0] p_tx, p_rx;                   // Peer data.
    logic [7:0]  g8;                           // Bits seen from the slave.
    logic        sclk_q;                       // Clock seen last cycle.
    int          n_mismatch, tests_run;        // Report counters.
    int          tog, t_first, t_last, cyc;    // Clock edge monitor.
    // Each wire takes the level of whoever drives it.
    wire logic   sclk_w = sclk_oe ? sclk_out : drv_sclk;
    wire logic   pin_a = dat_a_oe ? dat_a_out : (swp ? miso : drv_a);
    wire logic   pin_b = dat_b_oe ? dat_b_out : miso;

    sync_serial_channel sync_serial_channel_i (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .dat_a_in(pin_a),
        .dat_a_out(dat_a_out), .dat_a_oe(dat_a_oe), .dat_b_in(pin_b),
        .dat_b_out(dat_b_out), .dat_b_oe(dat_b_oe), .irq_tx(irq_tx),
        .irq_rx(irq_rx), .irq_err(irq_err), .irq(irq)
    );

    spi_peer spi_peer_i (
        .sclk(sclk_w), .mosi(swp ? pin_b : pin_a), .arm(arm),
        .cpol(p_cpol), .cpha(p_cpha), .msb(p_msb), .len(p_len),
        .tx(p_tx), .miso(miso), .rx(p_rx)
    );

    // The clock runs at 200 MHz.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Count master clock toggles and when the first and last came.
    always @(posedge clock) begin
        if (sclk_q !== sclk_out) begin
            if (tog == 0) t_first = cyc;
            t_last = cyc;
            tog++;
        end
        sclk_q = sclk_out;
        cyc++;
    end

    // Compare a value and report a mismatch at once.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    // Print the counts and the verdict, then end the run.
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // One APB transfer: setup, then access until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write and checked register read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check_val(rv, exp);
    endtask : rd

    // Wait, with a bound, for the combined interrupt.
    task automatic wait_irq;
        int n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        if (irq !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_irq

    // Reset values, an unmapped address and quiet outputs.
    task automatic t_reset;
        rd(`REG_CTRL, 32'h007);
        rd(`REG_BAUD, 32'h0);
        rd(`REG_MASK, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check_val(rv, 32'h0);
        check_val({31'h0, ev}, 32'h1);
        check_val({irq, sclk_oe, dat_a_oe, dat_b_oe}, 4'h0);
        $display("test reset done");
    endtask : t_reset

    // One master character; mode is {swap, cpha, cpol, msb first}.
    task automatic m_case(input logic [3:0] mode, input int len, input int rl,
                          input logic [15:0] td, input logic [15:0] pd);
        logic [15:0] mk;
        mk = 16'hFFFF >> (16 - len);
        swp <= mode[3];
        {p_cpha, p_cpol, p_msb} <= mode[2:0];
        p_len <= 5'(len);
        p_tx <= pd;
        wr(`REG_BAUD, rl);
        wr(`REG_CTRL, {20'h0, mode[3], 4'b0011, mode[2:0], 4'(len - 1)});
        repeat (3) @(posedge clock);
        tog = 0;
        arm <= 1'b1;
        wr(`REG_TXDATA, {16'h0, td});
        arm <= 1'b0;
        wait_irq;
        rd(`REG_RXDATA, {16'h0, pd & mk});
        check_val(p_rx, td & mk);
        check_val(tog, 2 * len);
        check_val(t_last - t_first, (2 * len - 1) * (rl + 1));
        check_val(sclk_out, mode[1]);
        apb(1'b0, `REG_STATUS, 32'h0);
    endtask : m_case

    // Master transfers over all four clock modes, lengths 2, 5, 8 and 16, and both pin choices.
    task automatic t_master;
        wr(`REG_MASK, 32'h02);
        m_case(4'b0001, 8, 2, 16'h00A5, 16'h003C);
        m_case(4'b0100, 2, 0, 16'h0002, 16'h0001);
        m_case(4'b1011, 16, 1, 16'hBEEF, 16'h1234);
        m_case(4'b0110, 5, 3, 16'h0015, 16'h000A);
        $display("test master done");
    endtask : t_master

    // Loop-back, masking, overrun and clear on status read.
    task automatic t_irq;
        wr(`REG_MASK, 32'h02);
        wr(`REG_CTRL, 32'h797);
        wr(`REG_TXDATA, 32'h5A);
        check_val({sclk_oe, dat_a_oe, dat_b_oe}, 3'h0);
        wait_irq;
        @(negedge clock);
        check_val({irq_tx, irq_rx, irq_err, irq}, 4'h5);
        wr(`REG_MASK, 32'h01);
        @(negedge clock);
        check_val({irq_tx, irq_rx, irq_err, irq}, 4'h9);
        wr(`REG_MASK, 32'h28);
        wr(`REG_TXDATA, 32'h5A);
        wait_irq;
        @(negedge clock);
        check_val({irq_tx, irq_rx, irq_err, irq}, 4'h3);
        rd(`REG_STATUS, 32'h0B);
        rd(`REG_STATUS, 32'h00);
        check_val(irq, 1'b0);
        rd(`REG_RXDATA, 32'h5A);
        $display("test interrupts done");
    endtask : t_irq

    // Bench as external master: eight bits, MSB first, phase 0.
    task automatic slv_frame(input logic [7:0] d, input int gap,
                             input logic late);
        for (int i = 7; i >= 0; i--) begin
            drv_a <= d[i];
            repeat (gap) @(posedge clock);
            drv_sclk <= 1'b1;
            g8[i] = pin_b;
            if (late) begin
                @(posedge clock);
                drv_a <= ~d[i];
            end
            repeat (gap) @(posedge clock);
            drv_sclk <= 1'b0;
        end
        repeat (4) @(posedge clock);
    endtask : slv_frame

    // Slave transfer, then baud, phase and transmit errors.
    task automatic t_slave;
        logic [31:0] eb[3] = '{32'h20, 32'h10, 32'h04};
        wr(`REG_CTRL, 32'h117);
        wr(`REG_TXDATA, 32'hC3);
        slv_frame(8'h96, 3, 1'b0);
        check_val(g8, 8'hC3);
        rd(`REG_RXDATA, 32'h96);
        apb(1'b0, `REG_STATUS, 32'h0);
        check_val(rv & 32'h3C, 32'h0);
        for (int e = 0; e < 3; e++) begin
            wr(`REG_CTRL, 32'h007);
            wr(`REG_CTRL, 32'h117);
            if (e < 2) wr(`REG_TXDATA, 32'hC3);
            slv_frame(8'h96, (e == 0) ? 1 : 3, e == 1);
            apb(1'b0, `REG_STATUS, 32'h0);
            check_val(rv & eb[e], eb[e]);
        end
        apb(1'b0, `REG_STATUS, 32'h0);
        check_val(rv & 32'h3C, 32'h0);
        $display("test slave done");
    endtask : t_slave

    // Main sequence: inputs set at time zero, reset for 12 cycles.
    initial begin
        {psel, penable, pwrite, drv_sclk, drv_a, swp, arm} = 7'h00;
        {p_cpol, p_cpha, p_msb, p_len, p_tx} = 24'h000000;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        tests_run = 0;
        {tog, cyc, t_first, t_last} = 128'h0;
        reset_n = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
        t_master;
        t_irq;
        t_slave;
        give_verdict;
    end
endmodule : tb_sync_serial_channel

`default_nettype wire
